// >>> logic/trs_consts.vh
/*
 Constants for the tightening result status block: register offsets,
 field positions, reset values and status encodings.
 Assumes inclusion by bare name from the design files.
*/
`ifndef TRS_CONSTS_VH
`define TRS_CONSTS_VH

// Register byte offsets
`define TRS_OFS_CTRL 8'h00
`define TRS_OFS_PGM_ANGLE 8'h04
`define TRS_OFS_RESULT 8'h08
`define TRS_OFS_STATUS_FLAGS 8'h0C
`define TRS_OFS_HS_ACK 8'h10
`define TRS_OFS_BATCH 8'h14
`define TRS_OFS_IRQ_STAT 8'h18
`define TRS_OFS_IRQ_MASK 8'h1C

// Control register bits: bits 0-4 are write-one pulse events, bits 5-6 are levels
`define TRS_CTRL_PGM_LOAD 0
`define TRS_CTRL_TIGHT_START 1
`define TRS_CTRL_JOB_SEL 2
`define TRS_CTRL_RESULT_DONE 3
`define TRS_CTRL_RESULT_RESET 4
`define TRS_CTRL_HS_REQ 5
`define TRS_CTRL_QUEUED 6

// Two-bit status codes
`define TRS_ST2_UNUSED 2'h0
`define TRS_ST2_OK 2'h1
`define TRS_ST2_HIGH 2'h2
`define TRS_ST2_LOW 2'h3

// ASCII status characters
`define TRS_ASC_OK 8'h4F
`define TRS_ASC_LOW 8'h4C
`define TRS_ASC_HIGH 8'h48
`define TRS_ASC_NONE 8'h00

// Handshake acknowledge codes
`define TRS_ACK_READ 8'h01
`define TRS_ACK_SKIP 8'h02
`define TRS_ACK_FLUSH 8'h04
`define TRS_ACK_QUEUED 8'h08

// Number of monitored parameters
`define TRS_NPAR 4

// Interrupt status bits
`define TRS_IRQ_RESULT 0
`define TRS_IRQ_PGM 1
`define TRS_IRQ_BATCH 2
`define TRS_IRQ_REHIT 3
`define TRS_IRQ_W 4

// Reset values
`define TRS_RST_W16 16'h0000
`define TRS_RST_W8 8'h00

`endif

// >>> logic/trs_param_status.v
/*
 One monitored result parameter: holds its 2-bit status and derives the
 ASCII code and the single-bit high/low/OK flags from it.
 Assumes load and clear are one-cycle pulses on ref_clk.
*/
`timescale 1ns/1ns
`include "trs_consts.vh"

module trs_param_status (
	input wire ref_clk,
	input wire rst_n,
	input wire load,
	input wire [1:0] load_code,
	input wire clear,
	output reg [1:0] code_reg,
	output reg [7:0] ascii_reg,
	output reg high_reg,
	output reg low_reg,
	output reg ok_reg
);
	reg [1:0] code_next;

	// Clear wins only if no result arrives in the same cycle
	always @* begin
		code_next = code_reg;
		if (clear)
			code_next = `TRS_ST2_UNUSED;
		if (load)
			code_next = load_code;
	end

	// All encodings registered together so outputs stay coherent
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			code_reg <= `TRS_ST2_UNUSED;
			ascii_reg <= `TRS_ASC_NONE;
			high_reg <= 1'b0;
			low_reg <= 1'b0;
			ok_reg <= 1'b0;
		end else begin
			code_reg <= code_next;
			high_reg <= (code_next == `TRS_ST2_HIGH);
			low_reg <= (code_next == `TRS_ST2_LOW);
			ok_reg <= (code_next == `TRS_ST2_OK);
			case (code_next)
				`TRS_ST2_OK: ascii_reg <= `TRS_ASC_OK;
				`TRS_ST2_HIGH: ascii_reg <= `TRS_ASC_HIGH;
				`TRS_ST2_LOW: ascii_reg <= `TRS_ASC_LOW;
				default: ascii_reg <= `TRS_ASC_NONE;
			endcase
		end
	end
endmodule // trs_param_status

// >>> logic/trs_result_status.v
/*
 Tightening result status outputs toward a fieldbus master, with a
 classic Wishbone slave for software and one level interrupt.
 Assumes a single 125 MHz ref_clk, async active-low reset, and that the
 fieldbus side samples the registered output ports directly.
*/
`timescale 1ns/1ns
`include "trs_consts.vh"

// Function
// - Hold program target angle until next load
// - Per-parameter status: ASCII, 2-bit, single flags
// - Handshake ack: queued bit ORed with requested action bit
// - Rehit flag loaded from its staging bit by result, cleared by reset
// - Remaining batch count refreshed on change
module trs_result_status (
	input wire ref_clk,
	input wire rst_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	output reg wb_err_o,
	output reg [15:0] target_angle_reg,
	output wire [7:0] status_ascii_0,
	output wire [7:0] status_ascii_1,
	output wire [7:0] status_ascii_2,
	output wire [7:0] status_ascii_3,
	output wire [7:0] status_code,
	output wire [3:0] status_high,
	output wire [3:0] status_low,
	output wire [3:0] status_ok,
	output reg [7:0] hs_ack_reg,
	output reg rehit_reg,
	output reg [15:0] batch_remain_reg,
	output reg irq_reg
);
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	wire wr = req & wb_we_i;
	wire [7:0] ofs = {wb_adr_i[7:2], 2'b00};
	wire hit_ctrl = (ofs == `TRS_OFS_CTRL);
	wire known = (ofs <= `TRS_OFS_IRQ_MASK);

	// Staging registers written by software before an event pulse, then control levels, interrupt state and next-state values
	reg [15:0] angle_stage_reg;
	reg [7:0] result_stage_reg;
	reg rehit_stage_reg;
	reg [2:0] hs_code_reg;
	reg hs_req_reg;
	reg queued_reg;
	reg [`TRS_IRQ_W-1:0] irq_stat_reg;
	reg [`TRS_IRQ_W-1:0] irq_mask_reg;
	reg [`TRS_IRQ_W-1:0] irq_stat_next;
	reg [7:0] hs_ack_next;
	reg [`TRS_IRQ_W-1:0] irq_mask_next;
	reg [31:0] rd_next;

	// Control writes are one-cycle events, low byte lane only
	wire ctl_wr = wr & hit_ctrl & wb_sel_i[0];
	wire ev_pgm = ctl_wr & wb_dat_i[`TRS_CTRL_PGM_LOAD];
	wire ev_start = ctl_wr & wb_dat_i[`TRS_CTRL_TIGHT_START];
	wire ev_job = ctl_wr & wb_dat_i[`TRS_CTRL_JOB_SEL];
	wire ev_result = ctl_wr & wb_dat_i[`TRS_CTRL_RESULT_DONE];
	wire ev_rreset = ctl_wr & wb_dat_i[`TRS_CTRL_RESULT_RESET];
	wire clr_status = ev_start | ev_pgm | ev_job;
	wire batch_wr = wr & (ofs == `TRS_OFS_BATCH) & (wb_sel_i[1:0] != 2'b00);
	wire [15:0] batch_new = {wb_sel_i[1] ? wb_dat_i[15:8] : batch_remain_reg[15:8],
		wb_sel_i[0] ? wb_dat_i[7:0] : batch_remain_reg[7:0]};
	wire batch_chg = batch_wr & (batch_new != batch_remain_reg);

	// Per-parameter status holders, one instance per monitored item
	wire [7:0] ascii_w [0:`TRS_NPAR-1];
	genvar gi;
	generate
		for (gi = 0; gi < `TRS_NPAR; gi = gi + 1) begin : g_par
			trs_param_status u_par (
				.ref_clk(ref_clk),
				.rst_n(rst_n),
				.load(ev_result),
				.load_code(result_stage_reg[2*gi+1:2*gi]),
				.clear(clr_status),
				.code_reg(status_code[2*gi+1:2*gi]),
				.ascii_reg(ascii_w[gi]),
				.high_reg(status_high[gi]),
				.low_reg(status_low[gi]),
				.ok_reg(status_ok[gi])
			);
		end
	endgenerate
	assign status_ascii_0 = ascii_w[0];
	assign status_ascii_1 = ascii_w[1];
	assign status_ascii_2 = ascii_w[2];
	assign status_ascii_3 = ascii_w[3];

	// Ack byte: queued code ORed with the requested action while asked
	always @* begin
		hs_ack_next = `TRS_RST_W8;
		if (queued_reg)
			hs_ack_next = hs_ack_next | `TRS_ACK_QUEUED;
		if (hs_req_reg) begin
			case (hs_code_reg)
				3'h1: hs_ack_next = hs_ack_next | `TRS_ACK_READ;
				3'h2: hs_ack_next = hs_ack_next | `TRS_ACK_SKIP;
				3'h4: hs_ack_next = hs_ack_next | `TRS_ACK_FLUSH;
				default: hs_ack_next = hs_ack_next;
			endcase
		end
	end

	// Sticky interrupt bits; a new event beats a same-cycle clear
	always @* begin
		irq_stat_next = irq_stat_reg;
		if (wr & (ofs == `TRS_OFS_IRQ_STAT) & wb_sel_i[0])
			irq_stat_next = irq_stat_next & ~wb_dat_i[`TRS_IRQ_W-1:0];
		if (ev_result)
			irq_stat_next[`TRS_IRQ_RESULT] = 1'b1;
		if (ev_pgm)
			irq_stat_next[`TRS_IRQ_PGM] = 1'b1;
		if (batch_chg)
			irq_stat_next[`TRS_IRQ_BATCH] = 1'b1;
		if (ev_result & rehit_stage_reg)
			irq_stat_next[`TRS_IRQ_REHIT] = 1'b1;
	end

	// Mask as it stands after this edge, so the level never lags a mask write
	always @* begin
		irq_mask_next = irq_mask_reg;
		if (wr & (ofs == `TRS_OFS_IRQ_MASK) & wb_sel_i[0])
			irq_mask_next = wb_dat_i[`TRS_IRQ_W-1:0];
	end

	// Read mux; readback shows live block state, unmapped offsets read zero
	always @* begin
		case (ofs)
			`TRS_OFS_CTRL: rd_next = {21'h0, hs_code_reg, 1'b0, queued_reg, hs_req_reg, 5'h0};
			`TRS_OFS_PGM_ANGLE: rd_next = {target_angle_reg, angle_stage_reg};
			`TRS_OFS_RESULT: rd_next = {23'h0, rehit_stage_reg, result_stage_reg};
			`TRS_OFS_STATUS_FLAGS: rd_next = {11'h0, rehit_reg, status_ok, status_low, status_high, status_code};
			`TRS_OFS_HS_ACK: rd_next = {24'h0, hs_ack_reg};
			`TRS_OFS_BATCH: rd_next = {16'h0, batch_remain_reg};
			`TRS_OFS_IRQ_STAT: rd_next = {28'h0, irq_stat_reg};
			`TRS_OFS_IRQ_MASK: rd_next = {28'h0, irq_mask_reg};
			default: rd_next = 32'h00000000;
		endcase
	end

	// Bus answer: one registered pulse per taken request; a held request waits
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			wb_ack_o <= 1'b0;
			wb_err_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= req & known;
			wb_err_o <= req & ~known;
			wb_dat_o <= rd_next;
		end
	end

	// Software staging and control levels; only taken writes land here
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			angle_stage_reg <= `TRS_RST_W16;
			result_stage_reg <= `TRS_RST_W8;
			rehit_stage_reg <= 1'b0;
			hs_code_reg <= 3'h0;
			hs_req_reg <= 1'b0;
			queued_reg <= 1'b0;
			irq_mask_reg <= {`TRS_IRQ_W{1'b0}};
		end else begin
			if (ctl_wr) begin
				hs_req_reg <= wb_dat_i[`TRS_CTRL_HS_REQ];
				queued_reg <= wb_dat_i[`TRS_CTRL_QUEUED];
				if (wb_sel_i[1])
					hs_code_reg <= wb_dat_i[10:8];
			end
			if (wr & (ofs == `TRS_OFS_PGM_ANGLE)) begin
				if (wb_sel_i[0])
					angle_stage_reg[7:0] <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					angle_stage_reg[15:8] <= wb_dat_i[15:8];
			end
			if (wr & (ofs == `TRS_OFS_RESULT)) begin
				if (wb_sel_i[0])
					result_stage_reg <= wb_dat_i[7:0];
				if (wb_sel_i[1])
					rehit_stage_reg <= wb_dat_i[8];
			end
			irq_mask_reg <= irq_mask_next;
		end
	end

	// Fieldbus-facing items; each moves only on its own event
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			target_angle_reg <= `TRS_RST_W16;
			hs_ack_reg <= `TRS_RST_W8;
			rehit_reg <= 1'b0;
			batch_remain_reg <= `TRS_RST_W16;
		end else begin
			if (ev_pgm)
				target_angle_reg <= angle_stage_reg;
			// Result takes priority over a reset in the same write
			if (ev_result)
				rehit_reg <= rehit_stage_reg;
			else if (ev_rreset)
				rehit_reg <= 1'b0;
			if (batch_chg)
				batch_remain_reg <= batch_new;
			hs_ack_reg <= hs_ack_next;
		end
	end

	// Sticky status and level interrupt, registered together
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			irq_stat_reg <= {`TRS_IRQ_W{1'b0}};
			irq_reg <= 1'b0;
		end else begin
			irq_stat_reg <= irq_stat_next;
			irq_reg <= |(irq_stat_next & irq_mask_next);
		end
	end
endmodule // trs_result_status

// >>> tb/trs_checker.sv
/* Assertions on the result status block ports.
 Assumes a bind to trs_result_status and one clock. */
`timescale 1ns/1ns
module trs_checker (
	input wire ref_clk,
	input wire rst_n,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	input wire wb_ack_o,
	input wire [15:0] target_angle_reg,
	input wire [7:0] status_code,
	input wire [3:0] status_high,
	input wire [3:0] status_low,
	input wire [3:0] status_ok,
	input wire [7:0] hs_ack_reg,
	input wire rehit_reg,
	input wire [15:0] batch_remain_reg
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Taken writes; lane 0 carries the events
	wire tk = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o & wb_sel_i[0];
	wire cw = tk & (wb_adr_i[7:2] == 6'h00);
	reg v1, v2;
	reg [31:0] d1, d2;
	// Two edges of history, as outputs may land one edge late
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			{v1, v2, d1, d2} <= 66'h0;
		end else begin
			{v1, v2, d1, d2} <= {cw, v1, wb_dat_i, d1};
		end
	end
	wire [4:0] h = (v1 ? d1[4:0] : 5'h0) | (v2 ? d2[4:0] : 5'h0);
	function automatic [3:0] fl(input [7:0] c, input [1:0] k);
		for (int i = 0; i < 4; i++) fl[i] = c[2*i+:2] == k;
	endfunction
	function automatic [7:0] af(input [31:0] d);
		af = {4'h0, d[6], 3'h0} | (d[5] && d[10:8] inside {3'h1, 3'h2, 3'h4} ? {5'h0, d[10:8]} : 8'h0);
	endfunction
	sequence s_ctl; cw && wb_sel_i[1] ##2 1; endsequence
	sequence s_clr; cw && wb_dat_i[2:0] != 3'h0 && !wb_dat_i[3] ##2 1; endsequence
	sequence s_bat; tk && wb_adr_i[7:2] == 6'h05 && wb_sel_i[1] ##2 1; endsequence
	property p_angle; !$stable(target_angle_reg) |-> h[0]; endproperty
	a_angle: assert property (p_angle) else $error("angle moved without load");
	property p_flags; status_high == fl(status_code, 2'h2) && status_low == fl(status_code, 2'h3)
		&& status_ok == fl(status_code, 2'h1); endproperty
	a_flags: assert property (p_flags) else $error("flags disagree with code");
	property p_ack; s_ctl |-> hs_ack_reg == af($past(wb_dat_i, 2)); endproperty
	a_ack: assert property (p_ack) else $error("ack byte wrong");
	property p_rehit; !$stable(rehit_reg) |-> h[4:3] != 2'h0; endproperty
	a_rehit: assert property (p_rehit) else $error("rehit moved alone");
	property p_batch; s_bat |-> batch_remain_reg == $past(wb_dat_i[15:0], 2); endproperty
	a_batch: assert property (p_batch) else $error("batch not refreshed");
	property p_clr; s_clr |-> status_code == 8'h0 && status_ok == 4'h0; endproperty
	a_clr: assert property (p_clr) else $error("status not cleared");
	property p_hold; !$stable(status_code) |-> h[3:0] != 4'h0; endproperty
	a_hold: assert property (p_hold) else $error("status moved alone");
endmodule // trs_checker
bind trs_result_status trs_checker trs_checker_inst (.*);

// >>> tb/trs_fieldbus_master.sv
/* Fieldbus master model: cyclic image of the output items.
 Assumes the items are registered in the device. */
`timescale 1ns/1ns
module trs_fieldbus_master (
	input wire ref_clk,
	input wire [40:0] items,
	output reg [40:0] img
);
	// Poll every clock, like a fast line controller scan
	always @(posedge ref_clk) begin
		img <= items;
	end
endmodule // trs_fieldbus_master

// >>> tb/trs_result_status_tb.sv
/* Bench: Wishbone stimulus and an integer model of the items.
 Assumes the checker binds itself to the design. */
`timescale 1ns/1ns
module trs_result_status_tb;
	reg ref_clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, es;
	reg [7:0] adr = 8'h0;
	reg [3:0] sel = 4'h0;
	reg [31:0] dat = 32'h0, rd, rs = 32'h6AD6;
	wire [31:0] dout, asc;
	wire ack, err, irq, rehit;
	wire [15:0] ang, bat;
	wire [7:0] code, hs;
	wire [3:0] hi, lo, ok;
	wire [40:0] img;
	integer err_count = 0, checks = 0, i, k, c, j, ea = 0, er;
	always #4 ref_clk = ~ref_clk;
	trs_result_status trs_result_status_inst (.ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dout), .wb_ack_o(ack),
		.wb_err_o(err), .target_angle_reg(ang), .status_ascii_0(asc[7:0]), .status_ascii_1(asc[15:8]),
		.status_ascii_2(asc[23:16]), .status_ascii_3(asc[31:24]), .status_code(code), .status_high(hi),
		.status_low(lo), .status_ok(ok), .hs_ack_reg(hs), .rehit_reg(rehit), .batch_remain_reg(bat), .irq_reg(irq));
	trs_fieldbus_master trs_fieldbus_master_inst (.ref_clk(ref_clk), .items({ang, bat, hs, rehit}), .img(img));
	function [31:0] xs(input [31:0] v);
		xs = v ^ (v << 13);
		xs = xs ^ (xs >> 17);
		xs = xs ^ (xs << 5);
	endfunction
	task chk(input [63:0] s, input [63:0] e);
		checks++;
		if (s !== e) begin
			err_count++;
			$display("BAD %0t got %h want %h", $time, s, e);
		end
	endtask
	// Classic cycle; waits for ack or err, only the watchdog ends a hang
	task wb(input w, input [7:0] a, input [31:0] d);
		@(posedge ref_clk);
		{cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, 4'hF};
		do begin
			@(posedge ref_clk);
		end while (ack !== 1'h1 && err !== 1'h1);
		{rd, es} = {dout, err};
		{cyc, stb} <= 2'h0;
		#1;
	endtask
	task finish_test;
		if (err_count == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (6) @(posedge ref_clk);
		rst_n <= 1'h1;
		#1 chk({ang, bat, code, hs, rehit, irq}, 0);
		// Angle moves only on a program load
		for (i = 0; i < 3; i++) begin
			rs = xs(rs);
			wb(1'h1, 8'h04, rs);
			chk(ang, ea);
			ea = rs[15:0];
			wb(1'h1, 8'h00, 32'h1);
			wb(1'h0, 8'h04, 32'h0);
			chk({rd[31:16], img[40:25]}, {ea[15:0], ea[15:0]});
		end
		// Every code on every parameter; late rounds pair clear with done
		for (i = 0; i < 8; i++) begin
			rs = xs(rs);
			j = i < 4 ? 16'h1B1B >> 2 * i & 8'hFF : rs[7:0];
			er = rs[8];
			wb(1'h1, 8'h08, {23'h0, rs[8], j[7:0]});
			wb(1'h1, 8'h00, 32'h8);
			chk({code, rehit, img[0]}, {j[7:0], er[0], er[0]});
			for (k = 0; k < 4; k++) begin
				c = j >> 2 * k & 3;
				chk({hi[k], lo[k], ok[k], asc[8*k+:8]}, {c == 2, c == 3, c == 1, c == 0 ? 8'h0 : c == 1 ? "O" : c == 2 ? "H" : "L"});
			end
			wb(1'h1, 8'h00, 1 << i % 3 | (i > 5 ? 8 : 0));
			chk({code, rehit}, {i > 5 ? j[7:0] : 8'h0, er[0]});
		end
		wb(1'h1, 8'h00, 32'h10);
		chk(rehit, 0);
		wb(1'h1, 8'h08, 32'h100);
		wb(1'h1, 8'h00, 32'h18);
		chk(rehit, 1);
		wb(1'h0, 8'h0C, 32'h0);
		chk(rd[20:0], 21'h100000);
		// All eight action codes, random request and queued levels
		for (i = 0; i < 8; i++) begin
			rs = xs(rs);
			wb(1'h1, 8'h00, i << 8 | rs[1:0] << 5);
			chk(hs, (rs[1] ? 8 : 0) | (rs[0] && (i == 1 || i == 2 || i == 4) ? i : 0));
		end
		// Batch refresh; a repeated value must not interrupt
		wb(1'h1, 8'h18, 32'hF);
		wb(1'h1, 8'h1C, 32'h4);
		for (i = 0; i < 3; i++) begin
			rs = i == 2 ? rs : xs(rs);
			wb(1'h1, 8'h14, {16'h0, rs[15:0]});
			chk({bat, img[24:9], irq}, {rs[15:0], rs[15:0], i < 2});
			wb(1'h1, 8'h18, 32'h4);
		end
		wb(1'h1, 8'h1C, 32'h0);
		wb(1'h1, 8'h14, {16'h0, ~rs[15:0]});
		wb(1'h0, 8'h18, 32'h0);
		chk({irq, rd[3:0]}, 5'h4);
		wb(1'h1, 8'h1C, 32'h4);
		chk(irq, 1);
		wb(1'h1, 8'h18, 32'h4);
		chk(irq, 0);
		// Unmapped offset is refused with zero data
		wb(1'h0, 8'h20, 32'h0);
		chk({es, rd}, 33'h100000000);
		finish_test;
	end
	// Hang guard, far beyond the couple of hundred cycles used
	initial begin
		#100000;
		err_count++;
		finish_test;
	end
endmodule // trs_result_status_tb
